/* clock_network_selection.sv */
// clock distribution and selection: dynamic muxes, global buffers with
// glitch-free gating, regional lines, core and interface local networks
// assumes every clock source is foreign to clk and is sampled here;
// selects, maps and clock enables come from fabric logic on clk
`timescale 1ns/100ps
module clock_network_selection #(
  parameter int DYN_INPUTS = cns_pkg::DYN_INPUTS,
  parameter int SEL_W = $clog2(cns_pkg::DYN_INPUTS),
  parameter bit REGION_IS_EDGE = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [cns_pkg::NUM_DYN_MUX-1:0][DYN_INPUTS-1:0] dyn_src_in,
  input wire logic [cns_pkg::NUM_DYN_MUX-1:0] dyn_en,
  input wire logic [cns_pkg::NUM_DYN_MUX-1:0][SEL_W-1:0] dyn_sel,
  output logic [cns_pkg::NUM_DYN_MUX-1:0][SEL_W-1:0] dyn_active_sel,
  output logic [cns_pkg::NUM_DYN_MUX-1:0] dyn_busy,
  input wire logic [cns_pkg::NUM_GLOBAL-1:0] global_buffer_core_in,
  input wire logic [cns_pkg::NUM_GLOBAL-1:0] global_buffer_if_in,
  input wire logic [cns_pkg::NUM_GLOBAL-1:0] global_buffer_use_if,
  input wire logic [cns_pkg::NUM_GLOBAL-1:0] net_en,
  output logic [cns_pkg::NUM_GLOBAL-1:0] global_clock_line,
  input wire logic [cns_pkg::REGIONAL_EDGE-1:0][cns_pkg::GLOBAL_IDX_W-1:0] regional_map,
  output logic [cns_pkg::REGIONAL_EDGE-1:0] regional_line,
  input wire logic [cns_pkg::REMOTE_FABRIC-1:0] remote_fabric_in,
  input wire logic [cns_pkg::LOCAL_NETS-1:0] local_gen_in,
  input wire logic [cns_pkg::LOCAL_NETS-1:0][cns_pkg::LOCAL_LINES-1:0][cns_pkg::SRC_W-1:0] local_sel,
  output logic [cns_pkg::LOCAL_NETS-1:0][cns_pkg::LOCAL_LINES-1:0] local_line,
  input wire logic [3:0] cell_line_sel,
  input wire logic [cns_pkg::REGION_ROWS-1:0] cell_ce_in,
  output logic [cns_pkg::REGION_ROWS-1:0] cell_ce_out,
  output logic [cns_pkg::REGION_ROWS-1:0] cell_clk_out,
  input wire logic [cns_pkg::TB_IF_GLOBAL-1:0][cns_pkg::GLOBAL_IDX_W-1:0] tb_if_global_sel,
  input wire logic [cns_pkg::TB_IF_FABRIC-1:0] tb_if_fabric_in,
  output logic [cns_pkg::TB_IF_CLOCKS-1:0] tb_if_clk_out,
  input wire logic [cns_pkg::LR_IF_CLOCKS-1:0][cns_pkg::KIND_W-1:0] lr_slot_kind,
  input wire logic [cns_pkg::LR_IF_CLOCKS-1:0][cns_pkg::GLOBAL_IDX_W-1:0] lr_slot_idx,
  input wire logic [cns_pkg::LR_IF_FABRIC_MAX-1:0] lr_fabric_in,
  output logic [cns_pkg::LR_IF_CLOCKS-1:0] lr_if_clk_out,
  output logic lr_fabric_excess,
  input wire logic gpio_alt_in,
  output logic pll_ref_out
);
  import cns_pkg::*;

  localparam int REG_COUNT = REGION_IS_EDGE ? REGIONAL_EDGE : REGIONAL_OTHER;
  localparam int ASYNC_W = 2 * NUM_GLOBAL + REMOTE_FABRIC + LOCAL_NETS + TB_IF_FABRIC
                           + LR_IF_FABRIC_MAX + 1;
  localparam int OFS_IF = NUM_GLOBAL;
  localparam int OFS_REMOTE = 2 * NUM_GLOBAL;
  localparam int OFS_GEN = OFS_REMOTE + REMOTE_FABRIC;
  localparam int OFS_TB = OFS_GEN + LOCAL_NETS;
  localparam int OFS_LR = OFS_TB + TB_IF_FABRIC;
  localparam int OFS_ALT = OFS_LR + LR_IF_FABRIC_MAX;

  if (NUM_DYN_MUX != DYN_MUX_PER_SIDE * DIE_SIDES || NUM_DYN_MUX > NUM_GLOBAL) begin : g_bad_mux
    $error("clock_network_selection: dynamic mux count inconsistent");
  end
  if (TB_IF_GLOBAL + TB_IF_FABRIC != TB_IF_CLOCKS || LOCAL_NETS != BLOCK_NET + 1) begin : g_bad_if
    $error("clock_network_selection: interface region widths inconsistent");
  end

  // =====================================================================
  // decode helpers
  function automatic logic pick_local(input logic [SRC_W-1:0] code,
                                      input logic [NUM_GLOBAL-1:0] glob,
                                      input logic [REMOTE_FABRIC-1:0] remote,
                                      input logic [REGIONAL_EDGE-1:0] regional,
                                      input logic gen);
    logic r;
    r = 1'b0;
    if (code < SRC_REMOTE_BASE) begin
      r = glob[code[4:0]];
    end else if (code < SRC_REGIONAL_BASE) begin
      r = remote[code[3:0]];
    end else if (code < SRC_LOCAL_GEN) begin
      r = (int'(code[2:0]) < REG_COUNT) ? regional[code[2:0]] : 1'b0;
    end else if (code == SRC_LOCAL_GEN) begin
      r = gen;
    end
    return r;
  endfunction

  function automatic int row_to_net(input int row);
    return (row < LOCAL_ROWS) ? 0 : 1;
  endfunction

  // =====================================================================
  // sampling of foreign clock sources
  logic [ASYNC_W-1:0] async_in;
  logic [ASYNC_W-1:0] async_s1_reg;
  logic [ASYNC_W-1:0] async_s2_reg;

  assign async_in = {gpio_alt_in, lr_fabric_in, tb_if_fabric_in, local_gen_in,
                     remote_fabric_in, global_buffer_if_in, global_buffer_core_in};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      async_s1_reg <= '0;
      async_s2_reg <= '0;
    end else begin
      async_s1_reg <= async_in;
      async_s2_reg <= async_s1_reg;
    end
  end

  // =====================================================================
  // dynamic muxes, two per side, feeding the lowest global lines
  logic [NUM_DYN_MUX-1:0] dyn_out;

  for (genvar m = 0; m < NUM_DYN_MUX; m++) begin : g_dyn
    cns_dyn_mux #(
      .NUM_IN(DYN_INPUTS),
      .SEL_W(SEL_W)
    ) u_mux (
      .clk(clk),
      .rstn(rstn),
      .src_in(dyn_src_in[m]),
      .en(dyn_en[m]),
      .sel(dyn_sel[m]),
      .clk_out(dyn_out[m]),
      .active_sel(dyn_active_sel[m]),
      .busy(dyn_busy[m])
    );
  end

  // =====================================================================
  // global buffers with per-network glitch-free enable
  logic [NUM_GLOBAL-1:0] gsrc_raw;
  logic [NUM_GLOBAL-1:0] gate_en_reg;
  logic [NUM_GLOBAL-1:0] global_reg;

  for (genvar g = 0; g < NUM_GLOBAL; g++) begin : g_global_buffer
    if (g < NUM_DYN_MUX) begin : g_from_mux
      assign gsrc_raw[g] = dyn_out[g];
    end else begin : g_from_src
      assign gsrc_raw[g] = global_buffer_use_if[g] ? async_s2_reg[OFS_IF + g]
                                                   : async_s2_reg[g];
    end

    // enable only moves while the source is low, so no runt edge escapes
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        gate_en_reg[g] <= 1'b0;
      end else if (!gsrc_raw[g]) begin
        gate_en_reg[g] <= net_en[g];
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        global_reg[g] <= 1'b0;
      end else begin
        global_reg[g] <= gsrc_raw[g] & gate_en_reg[g];
      end
    end

    a_gate_when_low: assert property (@(posedge clk) disable iff (!rstn)
      (gate_en_reg[g] != $past(gate_en_reg[g])) |-> !$past(gsrc_raw[g]))
      else $error("network enable changed during a high phase");
  end

  assign global_clock_line = global_reg;

  // =====================================================================
  // regional lines driven from the global buffers
  logic [REGIONAL_EDGE-1:0] regional_reg;

  for (genvar k = 0; k < REGIONAL_EDGE; k++) begin : g_regional
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        regional_reg[k] <= 1'b0;
      end else if (k < REG_COUNT) begin
        regional_reg[k] <= gsrc_raw[regional_map[k]] & gate_en_reg[regional_map[k]];
      end else begin
        regional_reg[k] <= 1'b0;
      end
    end
  end

  assign regional_line = regional_reg;

  a_regional_cap: assert property (@(posedge clk) disable iff (!rstn)
    (regional_reg >> REG_COUNT) == '0)
    else $error("regional line beyond region allowance is active");

  // =====================================================================
  // core local networks: two half-column nets and one block net
  logic [LOCAL_NETS-1:0][LOCAL_LINES-1:0] local_reg;

  for (genvar n = 0; n < LOCAL_NETS; n++) begin : g_net
    for (genvar l = 0; l < LOCAL_LINES; l++) begin : g_line
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          local_reg[n][l] <= 1'b0;
        end else begin
          local_reg[n][l] <= pick_local(local_sel[n][l], global_reg,
                                        async_s2_reg[OFS_REMOTE +: REMOTE_FABRIC],
                                        regional_reg, async_s2_reg[OFS_GEN + n]);
        end
      end
    end
  end

  assign local_line = local_reg;

  // =====================================================================
  // per-cell clock enable and clock from its half-column network
  logic [REGION_ROWS-1:0] cell_ce_reg;
  logic [REGION_ROWS-1:0] cell_clk_reg;

  for (genvar r = 0; r < REGION_ROWS; r++) begin : g_cell
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        cell_ce_reg[r] <= 1'b0;
        cell_clk_reg[r] <= 1'b0;
      end else begin
        cell_ce_reg[r] <= cell_ce_in[r];
        cell_clk_reg[r] <= local_reg[row_to_net(r)][cell_line_sel];
      end
    end

    a_cell_net: assert property (@(posedge clk) disable iff (!rstn)
      ##1 cell_clk_reg[r] == $past(local_reg[row_to_net(r)][cell_line_sel]))
      else $error("cell clock taken from wrong half-column network");
  end

  assign cell_ce_out = cell_ce_reg;
  assign cell_clk_out = cell_clk_reg;

  a_cell_ce: assert property (@(posedge clk) disable iff (!rstn)
    $rose(cell_ce_in[0]) |=> cell_ce_reg[0] ##1 (cell_ce_reg[0] == $past(cell_ce_in[0])))
    else $error("cell clock enable not passed through");

  // =====================================================================
  // top/bottom interface region: 14 global plus 2 fabric clocks
  logic [TB_IF_CLOCKS-1:0] tb_reg;

  // split at elaboration so no slot indexes past the select array
  for (genvar t = 0; t < TB_IF_CLOCKS; t++) begin : g_tb
    if (t < TB_IF_GLOBAL) begin : g_glob
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          tb_reg[t] <= 1'b0;
        end else begin
          tb_reg[t] <= global_reg[tb_if_global_sel[t]];
        end
      end
    end else begin : g_fab
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          tb_reg[t] <= 1'b0;
        end else begin
          tb_reg[t] <= async_s2_reg[OFS_TB + t - TB_IF_GLOBAL];
        end
      end
    end
  end

  assign tb_if_clk_out = tb_reg;

  // =====================================================================
  // left/right interface region: 4 clocks, fabric slots capped
  logic [LR_IF_CLOCKS-1:0] lr_allow;
  logic [LR_IF_CLOCKS-1:0] lr_reg;
  logic lr_excess_reg;
  logic [2:0] lr_fab_used;
  logic [2:0] lr_fab_asked;

  // fabric slots past the cap read low rather than steal a global slot
  always_comb begin
    lr_fab_used = 3'h0;
    lr_fab_asked = 3'h0;
    for (int s = 0; s < LR_IF_CLOCKS; s++) begin
      lr_allow[s] = 1'b1;
      if (lr_slot_kind[s] == KIND_FABRIC) begin
        lr_fab_asked = lr_fab_asked + 3'h1;
        if (int'(lr_fab_used) < LR_IF_FABRIC_MAX) begin
          lr_fab_used = lr_fab_used + 3'h1;
        end else begin
          lr_allow[s] = 1'b0;
        end
      end
    end
  end

  for (genvar s = 0; s < LR_IF_CLOCKS; s++) begin : g_lr
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        lr_reg[s] <= 1'b0;
      end else begin
        case (lr_slot_kind[s])
          KIND_GLOBAL: lr_reg[s] <= global_reg[lr_slot_idx[s]];
          KIND_REGIONAL: lr_reg[s] <= regional_reg[lr_slot_idx[s][2:0]];
          KIND_FABRIC: lr_reg[s] <= lr_allow[s] & async_s2_reg[OFS_LR + lr_slot_idx[s][0]];
          default: lr_reg[s] <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lr_excess_reg <= 1'b0;
    end else begin
      lr_excess_reg <= (int'(lr_fab_asked) > LR_IF_FABRIC_MAX);
    end
  end

  assign lr_if_clk_out = lr_reg;
  assign lr_fabric_excess = lr_excess_reg;

  a_lr_fabric_cap: assert property (@(posedge clk) disable iff (!rstn)
    (int'(lr_fab_asked) > LR_IF_FABRIC_MAX) |-> (int'(lr_fab_used) == LR_IF_FABRIC_MAX)
    ##1 lr_excess_reg)
    else $error("left/right region accepted too many fabric clocks");

  // =====================================================================
  // alternate-mode pin straight to the neighbouring interface block
  logic pll_ref_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_ref_reg <= 1'b0;
    end else begin
      pll_ref_reg <= async_s2_reg[OFS_ALT];
    end
  end

  assign pll_ref_out = pll_ref_reg;

  a_alt_pass: assert property (@(posedge clk) disable iff (!rstn)
    $rose(async_s2_reg[OFS_ALT]) |=> pll_ref_reg ##1 (pll_ref_reg == $past(async_s2_reg[OFS_ALT])))
    else $error("alternate pin not forwarded to reference output");

endmodule

/* cns_dyn_mux.sv */
// one run-time switchable clock multiplexer with glitch-free changeover
// assumes sel and en come from logic on clk; src_in are foreign clocks
`timescale 1ns/100ps
module cns_dyn_mux #(
  parameter int NUM_IN = cns_pkg::DYN_INPUTS,
  parameter int SEL_W = $clog2(cns_pkg::DYN_INPUTS)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [NUM_IN-1:0] src_in,
  input wire logic en,
  input wire logic [SEL_W-1:0] sel,
  output logic clk_out,
  output logic [SEL_W-1:0] active_sel,
  output logic busy
);
  import cns_pkg::*;

  if (NUM_IN < 2 || (1 << SEL_W) < NUM_IN) begin : g_bad_param
    $error("cns_dyn_mux: select too narrow for input count");
  end

  // =====================================================================
  // input sampling
  logic [NUM_IN-1:0] src_s1_reg;
  logic [NUM_IN-1:0] src_s2_reg;
  cns_sw_state_t state_reg;
  logic [SEL_W-1:0] active_reg;
  logic [SEL_W-1:0] target_reg;
  logic [SEL_W-1:0] req;
  logic clk_out_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
    end else begin
      src_s1_reg <= src_in;
      src_s2_reg <= src_s1_reg;
    end
  end

  // =====================================================================
  // request: disabled mux stays on the default input
  always_comb begin
    req = active_reg;
    if (!en) begin
      req = SEL_W'(DEFAULT_INPUT);
    end else if (int'(sel) < NUM_IN) begin
      req = sel;
    end
  end

  // =====================================================================
  // changeover: drop old clock at its low phase, take new one at its low
  // phase; a clock stopped high on either side stalls the switch here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CNS_RUN;
    end else begin
      case (state_reg)
        CNS_RUN: begin
          if (req != active_reg) state_reg <= CNS_DRAIN;
        end
        CNS_DRAIN: begin
          if (!src_s2_reg[active_reg]) state_reg <= CNS_ARM;
        end
        CNS_ARM: begin
          if (!src_s2_reg[target_reg]) state_reg <= CNS_RUN;
        end
        default: state_reg <= CNS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      target_reg <= SEL_W'(DEFAULT_INPUT);
    end else if (state_reg == CNS_RUN && req != active_reg) begin
      target_reg <= req;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_reg <= SEL_W'(DEFAULT_INPUT);
    end else if (state_reg == CNS_ARM && !src_s2_reg[target_reg]) begin
      active_reg <= target_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_out_reg <= 1'b0;
    end else if (state_reg == CNS_ARM) begin
      clk_out_reg <= 1'b0;
    end else begin
      clk_out_reg <= src_s2_reg[active_reg];
    end
  end

  assign clk_out = clk_out_reg;
  assign active_sel = active_reg;
  assign busy = (state_reg != CNS_RUN);

  // =====================================================================
  // checks
  a_drain_waits_low: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == CNS_DRAIN && src_s2_reg[active_reg]) |=> state_reg == CNS_DRAIN)
    else $error("switch left old clock during its high phase");
  a_arm_holds_low: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == CNS_ARM) |=> !clk_out_reg)
    else $error("output not held low while arming new clock");
  a_route_active: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == CNS_RUN) |=> clk_out_reg == $past(src_s2_reg[active_reg]))
    else $error("output does not follow the active input");
  a_default_input: assert property (@(posedge clk) disable iff (!rstn)
    (!en && state_reg == CNS_RUN && active_reg != SEL_W'(DEFAULT_INPUT))
    |=> state_reg == CNS_DRAIN ##1 target_reg == SEL_W'(DEFAULT_INPUT))
    else $error("disabled mux did not return to input 0");

endmodule

/* cns_fabric_model.sv */
// fabric-side model: free-running clocks on every mux input and every global core source
// assumes clk is the system clock of the block under test
`timescale 1ns/100ps
module cns_fabric_model (
  input wire logic clk,
  input wire logic rstn,
  output logic [cns_pkg::NUM_DYN_MUX-1:0][cns_pkg::DYN_INPUTS-1:0] dyn_src_in,
  output logic [cns_pkg::NUM_GLOBAL-1:0] global_buffer_core_in,
  output logic fabric_clk
);
  import cns_pkg::*;
  logic [3:0] cnt_reg;
  // =====================================================================
  // clock generation
  // never stops, so a changeover can always finish
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // input i toggles every 2**i cycles, input 0 fastest
  always_comb begin
    for (int m = 0; m < NUM_DYN_MUX; m++) begin
      dyn_src_in[m] = cnt_reg[DYN_INPUTS-1:0];
    end
  end
  assign global_buffer_core_in = {NUM_GLOBAL{cnt_reg[1]}};
  assign fabric_clk = cnt_reg[2];
endmodule

/* cns_pkg.sv */
// constants and types shared by the clock network selection logic
// assumes all clock sources are sampled on the single system clock clk
package cns_pkg;

  // =====================================================================
  // global network and dynamic multiplexers
  localparam int NUM_DYN_MUX = 8;
  localparam int DYN_MUX_PER_SIDE = 2;
  localparam int DIE_SIDES = 4;
  localparam int DYN_INPUTS = 4;
  localparam int DEFAULT_INPUT = 0;
  localparam int NUM_GLOBAL = 32;
  localparam int GLOBAL_IDX_W = 5;
  localparam int SYNC_STAGES = 2;

  // =====================================================================
  // local networks of a core region
  localparam int LOCAL_LINES = 16;
  localparam int REMOTE_FABRIC = 16;
  localparam int REGIONAL_EDGE = 8;
  localparam int REGIONAL_OTHER = 4;
  localparam int REGION_ROWS = 80;
  localparam int LOCAL_ROWS = 40;
  localparam int LOCAL_NETS = 3;
  localparam int BLOCK_NET = 2;
  localparam int SRC_W = 6;
  localparam logic [5:0] SRC_REMOTE_BASE = 6'h20;
  localparam logic [5:0] SRC_REGIONAL_BASE = 6'h30;
  localparam logic [5:0] SRC_LOCAL_GEN = 6'h38;

  // =====================================================================
  // interface local regions
  localparam int TB_IF_CLOCKS = 16;
  localparam int TB_IF_GLOBAL = 14;
  localparam int TB_IF_FABRIC = 2;
  localparam int LR_IF_CLOCKS = 4;
  localparam int LR_IF_FABRIC_MAX = 2;
  localparam int KIND_W = 2;
  localparam logic [1:0] KIND_GLOBAL = 2'h0;
  localparam logic [1:0] KIND_REGIONAL = 2'h1;
  localparam logic [1:0] KIND_FABRIC = 2'h2;

  typedef enum logic [2:0] {
    CNS_RUN = 3'b001,
    CNS_DRAIN = 3'b010,
    CNS_ARM = 3'b100
  } cns_sw_state_t;

endpackage

/* test_clock_network_selection.sv */
// self-checking bench for the clock network selection block
// assumes cns_pkg, the block and cns_fabric_model are compiled first
`timescale 1ns/100ps
module test_clock_network_selection;
  import cns_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, fclk, gpio_alt_in, lr_fabric_excess, pll_ref_out;
  logic [NUM_DYN_MUX-1:0][DYN_INPUTS-1:0] dyn_src_in;
  logic [NUM_DYN_MUX-1:0] dyn_en, dyn_busy;
  logic [NUM_DYN_MUX-1:0][1:0] dyn_sel, dyn_active_sel;
  logic [NUM_GLOBAL-1:0] global_buffer_core_in, global_buffer_if_in, global_buffer_use_if;
  logic [NUM_GLOBAL-1:0] net_en, global_clock_line;
  logic [REGIONAL_EDGE-1:0][GLOBAL_IDX_W-1:0] regional_map;
  logic [REGIONAL_EDGE-1:0] regional_line;
  logic [LOCAL_NETS-1:0][LOCAL_LINES-1:0][SRC_W-1:0] local_sel;
  logic [LOCAL_NETS-1:0][LOCAL_LINES-1:0] local_line;
  logic [3:0] cell_line_sel;
  logic [REGION_ROWS-1:0] cell_ce_in, cell_ce_out, cell_clk_out;
  logic [TB_IF_GLOBAL-1:0][GLOBAL_IDX_W-1:0] tb_if_global_sel;
  logic [TB_IF_CLOCKS-1:0] tb_if_clk_out;
  logic [LR_IF_CLOCKS-1:0][KIND_W-1:0] lr_slot_kind;
  logic [LR_IF_CLOCKS-1:0][GLOBAL_IDX_W-1:0] lr_slot_idx;
  logic [LR_IF_CLOCKS-1:0] lr_if_clk_out;
  // all clock outputs side by side: global 0, regional 32, local 40, tb 88, lr 104, cell 108
  logic [187:0] obs, obs_p;
  int tog [188];
  assign obs = {cell_clk_out, lr_if_clk_out, tb_if_clk_out, local_line, regional_line,
                global_clock_line};
  int err_total = 0, tests_run = 0;
  always #10 clk = ~clk;
  cns_fabric_model u_fab (.clk(clk), .rstn(rstn), .dyn_src_in(dyn_src_in),
    .global_buffer_core_in(global_buffer_core_in), .fabric_clk(fclk));
  clock_network_selection #(.REGION_IS_EDGE(1'b0)) u_dut (.clk(clk), .rstn(rstn),
    .dyn_src_in(dyn_src_in), .dyn_en(dyn_en), .dyn_sel(dyn_sel),
    .dyn_active_sel(dyn_active_sel), .dyn_busy(dyn_busy),
    .global_buffer_core_in(global_buffer_core_in),
    .global_buffer_if_in(global_buffer_if_in), .global_buffer_use_if(global_buffer_use_if),
    .net_en(net_en),
    .global_clock_line(global_clock_line), .regional_map(regional_map),
    .regional_line(regional_line), .remote_fabric_in({REMOTE_FABRIC{fclk}}),
    .local_gen_in({LOCAL_NETS{fclk}}), .local_sel(local_sel), .local_line(local_line),
    .cell_line_sel(cell_line_sel), .cell_ce_in(cell_ce_in), .cell_ce_out(cell_ce_out),
    .cell_clk_out(cell_clk_out), .tb_if_global_sel(tb_if_global_sel),
    .tb_if_fabric_in({TB_IF_FABRIC{fclk}}), .tb_if_clk_out(tb_if_clk_out),
    .lr_slot_kind(lr_slot_kind), .lr_slot_idx(lr_slot_idx),
    .lr_fabric_in({LR_IF_FABRIC_MAX{fclk}}), .lr_if_clk_out(lr_if_clk_out),
    .lr_fabric_excess(lr_fabric_excess), .gpio_alt_in(gpio_alt_in),
    .pll_ref_out(pll_ref_out));
  // =====================================================================
  // shared tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for every mux to leave its changeover
  task wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (dyn_busy === 8'h00) break;
    end
    if (i == 200) begin
      err_total++;
      end_sim();
    end
  endtask
  // counts edges of every clock output over 40 cycles
  task toggles;
    tog = '{default: 0};
    obs_p = obs;
    repeat (40) begin
      @(posedge clk);
      #1;
      for (int b = 0; b < 188; b++) begin
        if (obs[b] !== obs_p[b]) tog[b]++;
      end
      obs_p = obs;
    end
  endtask
  // =====================================================================
  // scenarios
  task t_switch;
    check("reset sel", dyn_active_sel, 32'h0);
    @(posedge clk);
    dyn_en <= 8'hFF;
    dyn_sel <= {NUM_DYN_MUX{2'h3}};
    @(posedge clk);
    #1;
    check("busy", dyn_busy, 32'hFF);
    wait_idle();
    check("switched sel", dyn_active_sel, 32'hFFFF);
    toggles();
    check("line0 runs", tog[0] > 1, 32'h1);
    @(posedge clk);
    dyn_en <= 8'h00;
    repeat (2) @(posedge clk);
    wait_idle();
    check("back to 0", dyn_active_sel, 32'h0);
    $display("test switch done");
  endtask
  task t_gate;
    @(posedge clk);
    net_en[8] <= 1'b0;
    repeat (6) @(posedge clk);
    toggles();
    check("gated", tog[8], 32'h0);
    @(posedge clk);
    net_en[8] <= 1'b1;
    toggles();
    check("core src", tog[8] > 4, 32'h1);
    check("if src", tog[9], 32'h0);
    $display("test gate done");
  endtask
  task t_misc;
    @(posedge clk);
    cell_ce_in <= 80'hA5;
    gpio_alt_in <= 1'b1;
    lr_slot_kind <= {LR_IF_CLOCKS{KIND_FABRIC}};
    @(posedge clk);
    #1;
    check("ce", cell_ce_out[31:0], 32'hA5);
    @(posedge clk);
    #1;
    check("alt early", pll_ref_out, 32'h0);
    @(posedge clk);
    #1;
    check("alt", pll_ref_out, 32'h1);
    check("excess", lr_fabric_excess, 32'h1);
    check("regional", regional_line[7:4], 32'h0);
    @(posedge clk);
    lr_slot_kind <= {KIND_FABRIC, KIND_FABRIC, KIND_GLOBAL, KIND_GLOBAL};
    repeat (3) @(posedge clk);
    #1;
    check("two fabric", lr_fabric_excess, 32'h0);
    $display("test misc done");
  endtask
  // line 8 runs from the core source, line 9 sits on the idle interface source
  task t_local;
    @(posedge clk);
    local_sel[0][0] <= 6'h08;
    local_sel[0][1] <= SRC_REGIONAL_BASE + 6'h04;
    local_sel[1][0] <= 6'h09;
    local_sel[1][1] <= SRC_REMOTE_BASE;
    local_sel[2][0] <= SRC_LOCAL_GEN;
    regional_map[0] <= 5'h08;
    tb_if_global_sel[0] <= 5'h08;
    tb_if_global_sel[1] <= 5'h09;
    lr_slot_idx[0] <= 5'h08;
    repeat (8) @(posedge clk);
    toggles();
    check("net0 global", tog[40] > 4, 32'h1);
    check("net0 regional", tog[41], 32'h0);
    check("net1 remote", tog[57] > 4, 32'h1);
    check("net2 gen", tog[72] > 4, 32'h1);
    check("row 39", tog[147] > 4, 32'h1);
    check("row 40", tog[148], 32'h0);
    check("regional", tog[32] > 4, 32'h1);
    check("tb global", tog[88] > 4, 32'h1);
    check("tb idle", tog[89], 32'h0);
    check("tb fabric", tog[102] > 4, 32'h1);
    check("lr global", tog[104] > 4, 32'h1);
    check("lr fabric", tog[107] > 4, 32'h1);
    $display("test local done");
  endtask
  initial begin
    dyn_en = 8'h00;
    dyn_sel = '0;
    global_buffer_if_in = 32'h0;
    global_buffer_use_if = 32'h200;
    net_en = 32'hFFFFFFFF;
    regional_map = '0;
    local_sel = '0;
    cell_line_sel = 4'h0;
    cell_ce_in = '0;
    tb_if_global_sel = '0;
    lr_slot_kind = '0;
    lr_slot_idx = '0;
    gpio_alt_in = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    t_switch();
    t_gate();
    t_misc();
    t_local();
    end_sim();
  end
endmodule
